// [common/pwm_pkg.sv]
/*
  Package for the position window monitor: widths, counts, register map,
  reset values and state encodings shared by the design files.
  Assumes a single 40 MHz system clock domain.
*/
package pwm_pkg;
  localparam int CHANNELS = 2;
  localparam int POSITIONS = 4;
  localparam int SCHEDULES = 15;
  localparam int SAMPLE_W = 16;
  localparam int SCHED_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // Window table: channel, schedule, position, bound (low/high)
  localparam int TAB_AW = 8;
  localparam int TAB_DEPTH = 256;
  // Register offsets
  localparam logic [ADDR_W-1:0] MODE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] BYPASS_OFS = 8'h01;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h02;
  localparam logic [ADDR_W-1:0] SAMPLE0_OFS = 8'h03;
  localparam logic [ADDR_W-1:0] SAMPLE1_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] TAB_ADDR_OFS = 8'h05;
  localparam logic [ADDR_W-1:0] TAB_DATA_OFS = 8'h06;
  // Mode register fields
  localparam int MODE_RUN_BIT = 0;
  localparam int MODE_TEACH_REQ_BIT = 1;
  localparam int MODE_SINGLE_BIT = 2;
  // Reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [CHANNELS-1:0] BYPASS_RST = 2'h0;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 16'h0000;
  localparam logic [TAB_AW-1:0] TAB_ADDR_RST = 8'h00;
  localparam logic [SCHED_W-1:0] SCHED_NONE = 4'h0;

  typedef enum logic [2:0] {
    ST_TEACH = 3'b001,
    ST_RUN = 3'b010,
    ST_RUN_TEACH = 3'b100
  } op_state_e;
endpackage : pwm_pkg

// [verilog/window_table.sv]
/*
  Simple dual-port window bound memory: one write port and a registered read port.
  Assumes write and read requests come from logic on the same clock.
*/
`timescale 1ns/1ps
module window_table
  import pwm_pkg::*;
(
  input wire logic clock,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [TAB_AW-1:0] wr_addr,
  input wire logic [SAMPLE_W-1:0] wr_data,
  input wire logic [TAB_AW-1:0] rd_addr,
  output logic [SAMPLE_W-1:0] rd_data_ff
);
  logic [SAMPLE_W-1:0] mem [TAB_DEPTH];

  // No reset: contents are taught by software before run mode
  always_ff @(posedge clock) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem[rd_addr];
    end
  end
endmodule : window_table

// [verilog/position_window_monitor.sv]
/*
  Position window monitor: two channels of 16-bit position samples compared
  with taught windows from fifteen schedules, four positions each.
  Assumes sample inputs come from an ADC interface on the same clock, with
  a one-cycle valid strobe, and schedule lines arrive from PLC pins.

// Overview of operation
// - Schedule number comes from four lines weighted 1, 2, 4, 8.
// - Each channel holds fifteen schedules selected by codes 1 to 15.
// - Each schedule has four positions with independent low and high bounds.
// - Two channels, each with own position and bypass outputs.
// - Position outputs low unless run mode and schedule code nonzero.
// - Position output high when sample lies inside that window.
// - Bypass output follows the channel's bypassed condition.
// - Run output high in run state, low in maintenance teach.
// - Teach output high in either teach mode or when requested.
// - Single-sensor variant drops run, teach and bypass outputs.
// - Position sampled as 16-bit value over 0 to 10 volts.
*/
`timescale 1ns/1ps
module position_window_monitor
  import pwm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [SCHED_W-1:0] schedule_in,
  input wire logic [SAMPLE_W-1:0] sample0,
  input wire logic [SAMPLE_W-1:0] sample1,
  input wire logic sample_valid,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata_ff,
  output logic [POSITIONS-1:0] window_out_first_ff,
  output logic [POSITIONS-1:0] window_out_second_ff,
  output logic [CHANNELS-1:0] bypass_flag_out_ff,
  output logic run_status_ff,
  output logic teach_status_ff
);
  // window_out_first_ff holds channel 0 positions 1..4, second channel 1.

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [TAB_AW-1:0] tab_index(
    input logic ch, input logic [SCHED_W-1:0] sch,
    input logic [1:0] pos, input logic hi);
    tab_index = {ch, sch[3:0] - 4'h1, pos, hi};
  endfunction : tab_index

  function automatic logic in_window(input logic [SAMPLE_W-1:0] s,
    input logic [SAMPLE_W-1:0] lo, input logic [SAMPLE_W-1:0] hi);
    // Both bounds count as inside the window
    in_window = (s >= lo) && (s <= hi);
  endfunction : in_window

  // ----------------------------------------------------------------------
  // Schedule line synchroniser
  // ----------------------------------------------------------------------
  // Only the second stage is read; the first may still be metastable
  logic [SCHED_W-1:0] sched_meta_ff, sched_sync_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      sched_meta_ff <= SCHED_NONE;
      sched_sync_ff <= SCHED_NONE;
    end else if (ce) begin
      sched_meta_ff <= schedule_in;
      sched_sync_ff <= sched_meta_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [2:0] mode_ff, nxt_mode;
  logic [CHANNELS-1:0] bypass_ff, nxt_bypass;
  logic [TAB_AW-1:0] tab_addr_ff, nxt_tab_addr;
  logic [SAMPLE_W-1:0] smp0_ff, nxt_smp0, smp1_ff, nxt_smp1;
  logic [DATA_W-1:0] nxt_rdata;
  logic tab_wr;
  logic [SAMPLE_W-1:0] tab_rdata;
  op_state_e state_ff, nxt_state;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_bypass = bypass_ff;
    nxt_tab_addr = tab_addr_ff;
    tab_wr = 1'b0;
    if (wr) begin
      if (addr == MODE_OFS) begin
        nxt_mode = wdata[2:0];
      end else if (addr == BYPASS_OFS) begin
        nxt_bypass = wdata[CHANNELS-1:0];
      end else if (addr == TAB_ADDR_OFS) begin
        nxt_tab_addr = wdata[TAB_AW-1:0];
      end else if (addr == TAB_DATA_OFS) begin
        tab_wr = 1'b1;
        nxt_tab_addr = tab_addr_ff + 8'h01;
      end
    end
  end

  // Read data: the table is write-only from software, so the sequencer
  // owns the memory read port and software never has to wait for it
  always_comb begin
    nxt_rdata = {DATA_W{1'b0}};
    if (rd) begin
      if (addr == MODE_OFS) begin
        nxt_rdata = {13'h0000, mode_ff};
      end else if (addr == BYPASS_OFS) begin
        nxt_rdata = {14'h0000, bypass_ff};
      end else if (addr == STATUS_OFS) begin
        nxt_rdata = {9'h000, state_ff, sched_sync_ff};
      end else if (addr == SAMPLE0_OFS) begin
        nxt_rdata = smp0_ff;
      end else if (addr == SAMPLE1_OFS) begin
        nxt_rdata = smp1_ff;
      end else if (addr == TAB_ADDR_OFS) begin
        nxt_rdata = {8'h00, tab_addr_ff};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Operating state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = ST_TEACH;
    if (mode_ff[MODE_RUN_BIT]) begin
      nxt_state = mode_ff[MODE_TEACH_REQ_BIT] ? ST_RUN_TEACH : ST_RUN;
    end
    case (state_ff)
      ST_TEACH, ST_RUN, ST_RUN_TEACH: ;
      default: nxt_state = ST_TEACH;
    endcase
  end

  // ----------------------------------------------------------------------
  // Compare sequencer: 32 reads after a sample, each of the 16 bounds of the channel pair read twice
  // ----------------------------------------------------------------------
  logic [4:0] seq_cnt_ff, nxt_seq_cnt;
  logic seq_busy_ff, nxt_seq_busy;
  logic [SCHED_W-1:0] seq_sched_ff, nxt_seq_sched;
  logic [SAMPLE_W-1:0] lo_ff, nxt_lo;
  logic [POSITIONS-1:0] hit0_ff, nxt_hit0, hit1_ff, nxt_hit1;
  logic [TAB_AW-1:0] rd_addr;
  logic [4:0] prev_cnt;
  logic [SAMPLE_W-1:0] cur_smp;
  logic win_ok;

  assign prev_cnt = seq_cnt_ff - 5'h01;
  assign rd_addr = seq_busy_ff ?
    tab_index(seq_cnt_ff[4], seq_sched_ff, seq_cnt_ff[3:2], seq_cnt_ff[0])
    : tab_addr_ff;

  always_comb begin
    nxt_seq_cnt = seq_cnt_ff;
    nxt_seq_busy = seq_busy_ff;
    nxt_seq_sched = seq_sched_ff;
    nxt_lo = lo_ff;
    nxt_hit0 = hit0_ff;
    nxt_hit1 = hit1_ff;
    nxt_smp0 = smp0_ff;
    nxt_smp1 = smp1_ff;
    cur_smp = prev_cnt[4] ? smp1_ff : smp0_ff;
    win_ok = in_window(cur_smp, lo_ff, tab_rdata);
    // The last high bound of channel 1 lands in the first cycle with busy low;
    // it is taken here so that a new sample cannot swallow it
    if (!seq_busy_ff && (seq_cnt_ff == 5'h1F)) begin
      nxt_hit1[3] = win_ok;
      nxt_seq_cnt = 5'h00;
    end
    // A sample while busy is dropped: samples must be 33 cycles apart
    if (sample_valid && !seq_busy_ff) begin
      nxt_smp0 = sample0;
      nxt_smp1 = sample1;
      nxt_seq_sched = sched_sync_ff;
      nxt_seq_busy = (sched_sync_ff != SCHED_NONE);
      nxt_seq_cnt = 5'h00;
    end else if (seq_busy_ff) begin
      // Data for the address issued last cycle arrives now
      if (seq_cnt_ff != 5'h00) begin
        if (!prev_cnt[0]) begin
          nxt_lo = tab_rdata;
        end else if (prev_cnt[4]) begin
          nxt_hit1[prev_cnt[3:2]] = win_ok;
        end else begin
          nxt_hit0[prev_cnt[3:2]] = win_ok;
        end
      end
      nxt_seq_cnt = seq_cnt_ff + 5'h01;
      if (seq_cnt_ff == 5'h1F) begin
        // Park on the last count so the final compare follows
        nxt_seq_busy = 1'b0;
        nxt_seq_cnt = 5'h1F;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------------
  logic [POSITIONS-1:0] nxt_win0, nxt_win1;
  logic [CHANNELS-1:0] nxt_bypass_out;
  logic nxt_run, nxt_teach, active;

  always_comb begin
    // Hits are kept across a schedule change; only the gate follows the
    // lines at once, so a new schedule shows fresh hits after one sample
    active = (state_ff != ST_TEACH) && (sched_sync_ff != SCHED_NONE);
    nxt_win0 = active ? hit0_ff : 4'h0;
    nxt_win1 = active ? hit1_ff : 4'h0;
    nxt_bypass_out = bypass_ff;
    nxt_run = (state_ff != ST_TEACH);
    nxt_teach = (state_ff != ST_RUN) || mode_ff[MODE_TEACH_REQ_BIT];
    if (mode_ff[MODE_SINGLE_BIT]) begin
      nxt_bypass_out = 2'h0;
      nxt_run = 1'b0;
      nxt_teach = 1'b0;
      nxt_win1 = 4'h0;
    end
  end

  // ----------------------------------------------------------------------
  // State registers, one block per group
  // ----------------------------------------------------------------------
  // Software registers and read data
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_ff <= MODE_RST;
      bypass_ff <= BYPASS_RST;
      tab_addr_ff <= TAB_ADDR_RST;
      rdata_ff <= {DATA_W{1'b0}};
    end else if (ce) begin
      mode_ff <= nxt_mode;
      bypass_ff <= nxt_bypass;
      tab_addr_ff <= nxt_tab_addr;
      rdata_ff <= nxt_rdata;
    end
  end

  // Operating state
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ST_TEACH;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // Sequencer and the samples it compares
  always_ff @(posedge clock) begin
    if (rst) begin
      smp0_ff <= SAMPLE_RST;
      smp1_ff <= SAMPLE_RST;
      seq_cnt_ff <= 5'h00;
      seq_busy_ff <= 1'b0;
      seq_sched_ff <= SCHED_NONE;
      lo_ff <= SAMPLE_RST;
      hit0_ff <= 4'h0;
      hit1_ff <= 4'h0;
    end else if (ce) begin
      smp0_ff <= nxt_smp0;
      smp1_ff <= nxt_smp1;
      seq_cnt_ff <= nxt_seq_cnt;
      seq_busy_ff <= nxt_seq_busy;
      seq_sched_ff <= nxt_seq_sched;
      lo_ff <= nxt_lo;
      hit0_ff <= nxt_hit0;
      hit1_ff <= nxt_hit1;
    end
  end

  // Output pins: reset drives every pin to its idle level
  always_ff @(posedge clock) begin
    if (rst) begin
      window_out_first_ff <= 4'h0;
      window_out_second_ff <= 4'h0;
      bypass_flag_out_ff <= 2'h0;
      run_status_ff <= 1'b0;
      teach_status_ff <= 1'b0;
    end else if (ce) begin
      window_out_first_ff <= nxt_win0;
      window_out_second_ff <= nxt_win1;
      bypass_flag_out_ff <= nxt_bypass_out;
      run_status_ff <= nxt_run;
      teach_status_ff <= nxt_teach;
    end
  end

  // Software writes and sequencer reads share one clock: no port conflict
  window_table u_table (
    .clock(clock),
    .ce(ce),
    .wr_en(tab_wr),
    .wr_addr(tab_addr_ff),
    .wr_data(wdata),
    .rd_addr(rd_addr),
    .rd_data_ff(tab_rdata)
  );
endmodule : position_window_monitor

// [sim/pwm_monitor.sv]
/*
  Checker on the monitor's ports; shadows mode and bypass writes.
  Assumes no register writes while ce is low, and one clock with
  synchronous reset.
*/
`timescale 1ns/1ps
module pwm_monitor
  import pwm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [SCHED_W-1:0] schedule_in,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic [POSITIONS-1:0] window_out_first_ff,
  input wire logic [POSITIONS-1:0] window_out_second_ff,
  input wire logic [CHANNELS-1:0] bypass_flag_out_ff,
  input wire logic run_status_ff,
  input wire logic teach_status_ff
);
  // ----------
  // Shadow state
  // ----------
  logic [2:0] mode_ff, nxt_mode, quiet_ff, nxt_quiet;
  logic [1:0] byp_ff, nxt_byp;
  logic settled, wz;
  // Assertions other than AST_SCHED_ZERO and AST_RESET_QUIET judge outputs only once a write has had time to land
  assign settled = quiet_ff == 3'h4;
  assign wz = window_out_first_ff == 4'h0 && window_out_second_ff == 4'h0;
  always_comb begin
    nxt_mode = mode_ff;
    nxt_byp = byp_ff;
    nxt_quiet = quiet_ff + {2'h0, !settled};
    if (wr && addr == MODE_OFS) begin
      nxt_mode = wdata[2:0];
      nxt_quiet = 3'h0;
    end
    if (wr && addr == BYPASS_OFS) begin
      nxt_byp = wdata[1:0];
      nxt_quiet = 3'h0;
    end
    if (rst) begin
      nxt_mode = MODE_RST;
      nxt_byp = BYPASS_RST;
      nxt_quiet = 3'h0;
    end
  end
  always_ff @(posedge clock) begin
    mode_ff <= nxt_mode;
    byp_ff <= nxt_byp;
    quiet_ff <= nxt_quiet;
  end
  // ----------
  // Assertions
  // ----------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  AST_RUN_LEVEL: assert property (
    settled |-> run_status_ff == (mode_ff[0] & ~mode_ff[2]))
    else $error("run status does not follow mode");
  AST_TEACH_LEVEL: assert property (
    settled |-> teach_status_ff == (~mode_ff[2] & (~mode_ff[0] | mode_ff[1])))
    else $error("teach status does not follow mode");
  AST_BYPASS_CH0: assert property (
    settled |-> bypass_flag_out_ff[0] == (byp_ff[0] & ~mode_ff[2]))
    else $error("channel 0 bypass wrong");
  AST_BYPASS_CH1: assert property (
    settled |-> bypass_flag_out_ff[1] == (byp_ff[1] & ~mode_ff[2]))
    else $error("channel 1 bypass wrong");
  AST_POS_NO_RUN: assert property (
    settled && !mode_ff[0] |-> wz)
    else $error("position output high outside run");
  AST_SINGLE_CH1: assert property (
    settled && mode_ff[2] |-> window_out_second_ff == 4'h0)
    else $error("second channel active in single variant");
  AST_SCHED_ZERO: assert property (
    (schedule_in == 4'h0) [*5] |-> wz)
    else $error("position output high with no schedule");
  AST_RESET_QUIET: assert property (
    $fell(rst) |-> wz && !run_status_ff && bypass_flag_out_ff == 2'h0)
    else $error("outputs not cleared by reset");
  COV_RUN_TEACH: cover property (settled && mode_ff == 3'h3);
  COV_HIT: cover property (window_out_first_ff != 4'h0);
  COV_SINGLE: cover property (settled && mode_ff[2]);
endmodule : pwm_monitor

// [sim/plc_model.sv]
/*
  PLC model driving the schedule lines.
  Assumes the design synchronises the lines itself.
*/
`timescale 1ns/1ps
module plc_model
  import pwm_pkg::*;
#(
  parameter int LINES = 4
)
(
  input wire logic clock,
  input wire logic [SCHED_W-1:0] code,
  output logic [SCHED_W-1:0] schedule_in
);
  // Lines above LINES are unwired and so tied low
  always @(posedge clock) begin
    schedule_in <= code & 4'(2 ** LINES - 1);
  end
endmodule : plc_model

// [sim/testbench.sv]
/*
  Bench: loads the window table, runs a table of cases, then corners.
  Assumes the PLC model drives the schedule lines; ce stays high except in the clock enable test.
*/
`timescale 1ns/1ps
module testbench
  import pwm_pkg::*;
;
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] byp;
    logic [3:0] sc;
    logic [15:0] s0;
    logic [15:0] s1;
    logic [11:0] exp;
  } row_s;
  // exp = {ch0 hits, ch1 hits, bypass, run, teach}
  row_s rows [7] = '{
    '{3'h1, 2'h0, 4'h1, 16'h0100, 16'h8200, 12'h142},
    '{3'h1, 2'h3, 4'hF, 16'hF900, 16'h7B01, 12'h80E},
    '{3'h3, 2'h1, 4'h2, 16'h43FF, 16'h0600, 12'h017},
    '{3'h0, 2'h0, 4'h4, 16'h0080, 16'h0080, 12'h001},
    '{3'h1, 2'h0, 4'h0, 16'h0080, 16'h0280, 12'h002},
    '{3'h1, 2'h2, 4'h3, 16'h4880, 16'hCA00, 12'h28A},
    '{3'h5, 2'h3, 4'h1, 16'h0080, 16'h0280, 12'h100}};
  logic clock, rst, ce, sample_valid, wr, rd, run, teach;
  logic [3:0] code, sched, w0, w1;
  logic [1:0] bp;
  logic [15:0] sample0, sample1, wdata, rdata;
  logic [7:0] addr, ib;
  logic [11:0] outv;
  int checks, n_mismatch, cyc;
  assign outv = {w0, w1, bp, run, teach};
  plc_model u_plc (.clock(clock), .code(code), .schedule_in(sched));
  position_window_monitor DUT (.clock(clock), .rst(rst), .ce(ce),
    .schedule_in(sched), .sample0(sample0), .sample1(sample1),
    .sample_valid(sample_valid), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_ff(rdata), .window_out_first_ff(w0),
    .window_out_second_ff(w1), .bypass_flag_out_ff(bp),
    .run_status_ff(run), .teach_status_ff(teach));
  // ----------
  // Tasks
  // ----------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    rd <= 1'h1;
    addr <= a;
    @(posedge clock);
    rd <= 1'h0;
    #1 chk(rdata, e);
  endtask : rd_chk
  // Waits out the synchroniser, then one evaluation pass
  task automatic samp(input logic [15:0] a, input logic [15:0] b);
    repeat (4) @(posedge clock);
    sample0 <= a;
    sample1 <= b;
    sample_valid <= 1'h1;
    @(posedge clock);
    sample_valid <= 1'h0;
    repeat (40) @(posedge clock);
    #1;
  endtask : samp
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // ----------
  // Stimulus
  // ----------
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    {rst, ce, sample_valid, wr, rd} = 5'h18;
    {code, sample0, sample1, wdata, addr} = '0;
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    repeat (3) @(posedge clock);
    #1 chk(16'(outv), 16'h0001);
    $display("reset test done");
    wr_reg(TAB_ADDR_OFS, 16'h0000);
    for (int i = 0; i < 256; i++) begin
      ib = 8'(i);
      wr_reg(TAB_DATA_OFS, {ib[2:1], ib[6:3], ib[7], 9'h000} + 16'(ib[0]) * 16'h0100);
    end
    foreach (rows[k]) begin
      wr_reg(MODE_OFS, 16'(rows[k].mode));
      wr_reg(BYPASS_OFS, 16'(rows[k].byp));
      code <= rows[k].sc;
      samp(rows[k].s0, rows[k].s1);
      chk(16'(outv), 16'(rows[k].exp));
      $display("row %0d done", k);
    end
    rd_chk(SAMPLE0_OFS, 16'h0080);
    rd_chk(SAMPLE1_OFS, 16'h0280);
    rd_chk(8'hFF, 16'h0000);
    rd_chk(TAB_DATA_OFS, 16'h0000);
    rd_chk(MODE_OFS, 16'h0005);
    rd_chk(BYPASS_OFS, 16'h0003);
    rd_chk(STATUS_OFS, {9'h000, ST_RUN, 4'h1});
    rd_chk(TAB_ADDR_OFS, 16'h0000);
    $display("register test done");
    wr_reg(MODE_OFS, 16'h0001);
    for (int s = 1; s < 16; s++) begin
      code <= 4'(s);
      samp({2'h0, 4'(s - 1), 10'h080}, {2'h0, 4'(s - 1), 10'h080});
      chk(16'({w0, w1}), 16'h0010);
    end
    $display("schedule test done");
    @(posedge clock);
    ce <= 1'h0;
    samp(16'hFFFF, 16'hFFFF);
    @(posedge clock);
    ce <= 1'h1;
    repeat (3) @(posedge clock);
    #1 chk(16'({w0, w1}), 16'h0010);
    $display("clock enable test done");
    code <= 4'h0;
    repeat (6) @(posedge clock);
    #1 chk(16'(w0), 16'h0000);
    @(posedge clock);
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    repeat (3) @(posedge clock);
    #1 chk(16'(outv), 16'h0001);
    $display("gating and reset test done");
    finish_test();
  end
endmodule : testbench
bind position_window_monitor pwm_monitor u_mon (.clock(clock), .rst(rst),
  .schedule_in(schedule_in), .addr(addr), .wdata(wdata), .wr(wr),
  .window_out_first_ff(window_out_first_ff),
  .window_out_second_ff(window_out_second_ff),
  .bypass_flag_out_ff(bypass_flag_out_ff), .run_status_ff(run_status_ff),
  .teach_status_ff(teach_status_ff));
